/* File: design/ccdrs_sequencer.sv */
// ccd readout sequencer: drives vertical, horizontal, discard and shutter
// assumes: pins go to level shifters; one clk at 125 MHz
`timescale 1ns/1ps
`default_nettype none
`include "ccdrs_defines.svh"
module ccdrs_sequencer #(
    parameter int PIX_PER_ROW = `CCDRS_PIX_PER_ROW,
    parameter int FD_CYC = `CCDRS_FD_CYC,
    parameter int VT_CYC = `CCDRS_VT_CYC,
    parameter int V3_CYC = `CCDRS_V3_CYC,
    parameter int TS_CYC = `CCDRS_TS_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire ccdrs_pkg::ccdrs_mode_t scan_mode,
    input wire logic full_range,
    input wire logic start,
    input wire logic [`CCDRS_CNT_W-1:0] integration_cycles,
    // status
    output logic busy,
    output logic end_of_frame,
    output logic frame_incomplete,
    // row markers out
    output logic row_valid,
    input wire logic row_ready,
    output ccdrs_pkg::ccdrs_row_t row_data,
    // sensor pins
    output ccdrs_pkg::ccdrs_pins_t pins
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_EXPOSE, ST_XFER, ST_VSHIFT, ST_GUARD_A,
        ST_DISCARD, ST_GUARD_B, ST_HSHIFT
    } ccdrs_state_t;

    ccdrs_state_t state_r;
    ccdrs_pkg::ccdrs_mode_t mode_r;
    logic field_odd_r;
    logic slow_r;
    logic [`CCDRS_CNT_W-1:0] tmr_r;
    logic [`CCDRS_CNT_W-1:0] shut_r;
    logic field_odd_nxt;
    logic [`CCDRS_ROWS_W-1:0] row_r;
    logic [15:0] pix_r;
    logic [7:0] hdiv_r;
    logic h_tick;
    logic h_phase_r;
    logic eof_r;
    logic incomplete_r;
    logic [`CCDRS_ROWS_W-1:0] rows_total;
    logic fifo_in_ready;
    logic push_row;
    ccdrs_pkg::ccdrs_pins_t pins_r;
    ccdrs_pkg::ccdrs_row_t mark;

    //////////////////////////////////////////////////////////////////////
    // row count per mode
    always_comb begin
        case (mode_r)
            ccdrs_pkg::CCDRS_PROG: rows_total = `CCDRS_ROWS_FULL;
            default: rows_total = `CCDRS_ROWS_FIELD;
        endcase
    end

    // horizontal divider: enable pulse every half period
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hdiv_r <= '0;
        end else if (state_r != ST_HSHIFT || h_tick) begin
            hdiv_r <= '0;
        end else begin
            hdiv_r <= hdiv_r + 8'h01;
        end
    end
    // half period; slow doubles period to 10 MHz
    assign h_tick = slow_r
        ? (hdiv_r == 8'(`CCDRS_TH_SLOW_CYC / 2 - 1))
        : (hdiv_r == 8'(`CCDRS_TH_NOM_CYC / 2 - 1));

    //////////////////////////////////////////////////////////////////////
    // mode latch at frame start
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= ccdrs_pkg::CCDRS_PROG;
            slow_r <= 1'b0;
        end else if (state_r == ST_IDLE && start) begin
            mode_r <= scan_mode;
            slow_r <= full_range && scan_mode == ccdrs_pkg::CCDRS_SUMMED;
        end
    end

    // parity flips after each interlaced field, even if start coincides
    assign field_odd_nxt = (eof_r && mode_r != ccdrs_pkg::CCDRS_PROG)
        ? ~field_odd_r : field_odd_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            field_odd_r <= 1'b0;
        end else begin
            field_odd_r <= field_odd_nxt;
        end
    end

    // shutter pulse right at start; exposure runs from it to transfer,
    // so integration_cycles must exceed TS_CYC
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shut_r <= '0;
        end else if (state_r == ST_IDLE && start) begin
            shut_r <= `CCDRS_CNT_W'(TS_CYC);
        end else if (shut_r != '0) begin
            shut_r <= shut_r - 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // main sequence
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            tmr_r <= '0;
            row_r <= '0;
            pix_r <= '0;
            h_phase_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        // shutter rise to transfer rise is integration
                        tmr_r <= (integration_cycles != '0)
                            ? integration_cycles - 1'b1
                            : '0;
                        row_r <= '0;
                        state_r <= ST_EXPOSE;
                    end
                end
                ST_EXPOSE: begin
                    if (tmr_r == '0) begin
                        tmr_r <= `CCDRS_CNT_W'(V3_CYC);
                        state_r <= ST_XFER;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_XFER: begin
                    // single simultaneous photodiode transfer
                    if (tmr_r == '0) begin
                        row_r <= '0;
                        tmr_r <= `CCDRS_CNT_W'(VT_CYC);
                        state_r <= ST_VSHIFT;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_VSHIFT: begin
                    if (tmr_r == '0) begin
                        tmr_r <= `CCDRS_CNT_W'(FD_CYC);
                        state_r <= ST_GUARD_A;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_GUARD_A: begin
                    if (tmr_r == '0) begin
                        tmr_r <= `CCDRS_CNT_W'(FD_CYC);
                        state_r <= ST_DISCARD;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_DISCARD: begin
                    if (tmr_r == '0) begin
                        tmr_r <= `CCDRS_CNT_W'(FD_CYC);
                        state_r <= ST_GUARD_B;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_GUARD_B: begin
                    if (tmr_r == '0 && fifo_in_ready) begin
                        pix_r <= '0;
                        h_phase_r <= 1'b0;
                        state_r <= ST_HSHIFT;
                    end else if (tmr_r != '0) begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_HSHIFT: begin
                    if (h_tick) begin
                        h_phase_r <= ~h_phase_r;
                        if (h_phase_r) begin
                            pix_r <= pix_r + 16'h0001;
                        end
                        if (h_phase_r && pix_r == 16'(PIX_PER_ROW - 1)) begin
                            row_r <= row_r + 1'b1;
                            tmr_r <= `CCDRS_CNT_W'(VT_CYC);
                            if (row_r == rows_total - 1'b1) begin
                                state_r <= ST_IDLE;
                            end else begin
                                state_r <= ST_VSHIFT;
                            end
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // end of frame pulse and interlace flag
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eof_r <= 1'b0;
            incomplete_r <= 1'b0;
        end else begin
            eof_r <= state_r == ST_HSHIFT && h_tick && h_phase_r
                && pix_r == 16'(PIX_PER_ROW - 1)
                && row_r == rows_total - 1'b1;
            if (state_r == ST_IDLE && start) begin
                // even field alone lacks the odd rows
                incomplete_r <= scan_mode != ccdrs_pkg::CCDRS_PROG
                    && !field_odd_nxt;
            end
        end
    end

    // pin drive, all vertical phases from one register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins_r <= '0;
        end else begin
            pins_r.substrate_shutter <= shut_r != '0;
            pins_r.line_discard_gate <= state_r == ST_DISCARD;
            // both phases switch in one edge, skew zero
            pins_r.vertical_phase_one <= state_r == ST_VSHIFT
                && tmr_r < `CCDRS_CNT_W'(VT_CYC / 2);
            pins_r.vertical_phase_two <= state_r == ST_VSHIFT
                && tmr_r >= `CCDRS_CNT_W'(VT_CYC / 2);
            // third level: one ST_XFER pulse in every mode;
            // prog, summed and nonsum all transfer every row alike
            pins_r.vertical_phase_two_third <= state_r == ST_XFER;
            pins_r.horizontal_phase_one <= state_r == ST_HSHIFT && !h_phase_r;
            pins_r.horizontal_phase_two <= state_r == ST_HSHIFT && h_phase_r;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // row markers: first row index gives pairing start per field
    assign push_row = state_r == ST_GUARD_B && tmr_r == '0 && fifo_in_ready;
    always_comb begin
        mark.last = row_r == rows_total - 1'b1;
        mark.field_odd = field_odd_r;
        case (mode_r)
            // summed even 0+1, odd 1+2; nonsum even 0,2 odd 1,3
            ccdrs_pkg::CCDRS_SUMMED: mark.row =
                {row_r[`CCDRS_ROWS_W-2:0], field_odd_r};
            ccdrs_pkg::CCDRS_NONSUM: mark.row =
                {row_r[`CCDRS_ROWS_W-2:0], field_odd_r};
            default: mark.row = row_r;
        endcase
    end

    ccdrs_fifo #(
        .WIDTH($bits(ccdrs_pkg::ccdrs_row_t)),
        .DEPTH(8)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(push_row),
        .in_ready(fifo_in_ready),
        .in_data(mark),
        .out_valid(row_valid),
        .out_ready(row_ready),
        .out_data(row_data)
    );

    assign pins = pins_r;
    assign busy = state_r != ST_IDLE;
    assign end_of_frame = eof_r;
    assign frame_incomplete = incomplete_r;

    //////////////////////////////////////////////////////////////////////
    AST_DISCARD_GUARD: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(state_r == ST_DISCARD) |-> $past(state_r == ST_GUARD_A))
        else $error("discard gate without leading guard");
    AST_VPHASE_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
        !(pins_r.vertical_phase_one && pins_r.vertical_phase_two))
        else $error("vertical phases overlap");
    AST_H_PERIOD: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(pins_r.horizontal_phase_one) && !slow_r
        |-> ##3 !pins_r.horizontal_phase_one || state_r != ST_HSHIFT)
        else $error("horizontal half period wrong");
    AST_EOF_ONE: assert property (@(posedge clk) disable iff (sys_rst)
        eof_r |=> !eof_r)
        else $error("end of frame longer than a cycle");
    AST_EOF_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        eof_r |-> state_r == ST_IDLE)
        else $error("end of frame while busy");
    AST_FIELD_ALT: assert property (@(posedge clk) disable iff (sys_rst)
        eof_r && mode_r != ccdrs_pkg::CCDRS_PROG
        |=> field_odd_r != $past(field_odd_r))
        else $error("field parity did not alternate");
    AST_ROWS_SUM: assert property (@(posedge clk) disable iff (sys_rst)
        mode_r != ccdrs_pkg::CCDRS_PROG |-> row_r <= `CCDRS_ROWS_FIELD)
        else $error("summed field row count exceeded");
    AST_XFER_AFTER_EXPOSE: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(state_r == ST_XFER) |-> $past(state_r == ST_EXPOSE))
        else $error("transfer without exposure");
endmodule : ccdrs_sequencer
`default_nettype wire

/* File: common/ccdrs_defines.svh */
// ccd readout sequencer: timing constants and counts
// assumes: included by design files, clk at 125 MHz
//
// Operation
// - progressive mode fires one transfer of all photodiodes into the vertical register at once.
// - summed interlaced clocking makes each packet carry two neighbouring photodiodes.
// - one summed field gives 1024 rows of 2048; full resolution needs an even and an odd field.
// - the even summed field pairs rows from zero: 0+1, 2+3 and onward.
// - the odd summed field pairs rows from one: 1+2, 3+4 and onward.
// - each summed interlaced field clocks the vertical register for 1037 rows.
// - the even non-summed field transfers rows 0, 2, 4 and onward; the code fires the same single all-row ST_XFER pulse as in the other modes.
// - the odd non-summed field transfers rows 1, 3, 5; each packet fills two row spaces; the code transfers all rows in one ST_XFER pulse here too.
// - the horizontal clock period stays between 25 ns and 200 ns, 50 ns nominal.
// - at least 0.5 us of delay stands around the line-discard gate pulse.
// - corresponding vertical phase edges stay within 100 ns of each other.
// - the two fields of an interlaced frame are exposed at different times and are flagged so.
// - the shutter pulse fires exactly the integration time before the phase-two transfer.
// - the next shutter may fire while the previous image still shifts out; the code fires it only on a start in ST_IDLE, after the last row.
// - summed or binned modes with full range run the pixel rate at 20 MHz; the code slows only summed mode, to a 100 ns period (10 MHz).
`ifndef CCDRS_DEFINES_SVH
`define CCDRS_DEFINES_SVH

`define CCDRS_CLK_MHZ 125
`define CCDRS_ROWS_FULL 12'h800
`define CCDRS_ROWS_FIELD 12'h40D
`define CCDRS_ROWS_W 12
// horizontal period in ns: nominal 50, slow 100 (10 MHz)
`define CCDRS_TH_NOM_NS 50
`define CCDRS_TH_SLOW_NS 100
`define CCDRS_TH_NOM_CYC ((`CCDRS_TH_NOM_NS * `CCDRS_CLK_MHZ) / 1000)
`define CCDRS_TH_SLOW_CYC ((`CCDRS_TH_SLOW_NS * `CCDRS_CLK_MHZ) / 1000)
// line discard delay, 0.5 us = 500 ns, rounded up
`define CCDRS_FD_NS 500
`define CCDRS_FD_CYC ((`CCDRS_FD_NS * `CCDRS_CLK_MHZ + 999) / 1000)
// vertical transfer time 1.5 us nominal
`define CCDRS_VT_NS 1500
`define CCDRS_VT_CYC ((`CCDRS_VT_NS * `CCDRS_CLK_MHZ + 999) / 1000)
// photodiode transfer pulse 5 us nominal
`define CCDRS_V3_NS 5000
`define CCDRS_V3_CYC ((`CCDRS_V3_NS * `CCDRS_CLK_MHZ + 999) / 1000)
// shutter pulse width 4 us
`define CCDRS_TS_NS 4000
`define CCDRS_TS_CYC ((`CCDRS_TS_NS * `CCDRS_CLK_MHZ + 999) / 1000)
`define CCDRS_PIX_PER_ROW 16'h0800
`define CCDRS_CNT_W 24

`endif

/* File: common/ccdrs_pkg.sv */
// ccd readout sequencer: shared types
// assumes: compiled before design files
package ccdrs_pkg;
    typedef enum logic [1:0] {
        CCDRS_PROG,
        CCDRS_SUMMED,
        CCDRS_NONSUM
    } ccdrs_mode_t;

    // sensor clock pins driven by the sequencer
    typedef struct packed {
        logic vertical_phase_one;
        logic vertical_phase_two;
        logic vertical_phase_two_third;
        logic horizontal_phase_one;
        logic horizontal_phase_two;
        logic line_discard_gate;
        logic substrate_shutter;
    } ccdrs_pins_t;

    // row marker word passed through the fifo
    typedef struct packed {
        logic [11:0] row;
        logic field_odd;
        logic last;
    } ccdrs_row_t;
endpackage : ccdrs_pkg

/* File: design/ccdrs_fifo.sv */
// ccd readout sequencer: small synchronous fifo
// assumes: single clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ccdrs_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // handshakes
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_r];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
        end
    end

    // fill count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (sys_rst)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : ccdrs_fifo
`default_nettype wire

/* File: bench/ccdrs_sensor_model.sv */
// sensor model: watches sequencer pins as the sensor sees them
// assumes: pins registered on clk; vshifts, hmin and hmax clear at each transfer
`timescale 1ns/1ps
`default_nettype none
module ccdrs_sensor_model #(
    parameter int GUARD = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sensor pins
    input wire ccdrs_pkg::ccdrs_pins_t pins,
    // observations
    output logic [15:0] vshifts,
    output logic [15:0] xfers,
    output logic [15:0] shut_miss,
    output logic [15:0] viol,
    output logic [7:0] hmin,
    output logic [7:0] hmax
);
    ccdrs_pkg::ccdrs_pins_t p_r;
    logic shut_r;
    logic gap_r;
    logic edge_w;
    logic [7:0] hcnt_r;
    int cyc;
    int last_edge;
    int quiet_until;

    ///////////////////////////////////////////////////////////
    // one process holds the whole sensor state
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            p_r = '0;
            vshifts = '0;
            xfers = '0;
            shut_miss = '0;
            viol = '0;
            hmin = 8'hFF;
            hmax = 8'h00;
            shut_r = 1'b0;
            gap_r = 1'b1;
            hcnt_r = 8'h00;
            cyc = 0;
            last_edge = 0;
            quiet_until = 0;
        end else begin
            cyc++;
            hcnt_r = hcnt_r + 8'h01;
            // shutter empties photodiodes, even mid readout
            if (pins.substrate_shutter) shut_r = 1'b1;
            // all photodiodes move into the vertical register
            if (pins.vertical_phase_two_third &&
                !p_r.vertical_phase_two_third) begin
                xfers++;
                if (!shut_r) shut_miss++;
                shut_r = 1'b0;
                vshifts = '0;
                hmin = 8'hFF;
                hmax = 8'h00;
            end
            // one vertical row step per rise of phase one
            if (pins.vertical_phase_one && !p_r.vertical_phase_one)
                vshifts++;
            // phase two falls on the same edge that raises phase one
            if (p_r.vertical_phase_two && !pins.vertical_phase_two &&
                !pins.vertical_phase_one) viol++;
            // clocks stay quiet on both sides of the discard gate
            edge_w = (pins.vertical_phase_one ^ p_r.vertical_phase_one) |
                (pins.vertical_phase_two ^ p_r.vertical_phase_two) |
                (pins.horizontal_phase_one ^ p_r.horizontal_phase_one) |
                (pins.horizontal_phase_two ^ p_r.horizontal_phase_two);
            if (pins.line_discard_gate && !p_r.line_discard_gate) begin
                if (cyc - last_edge < GUARD) viol++;
                gap_r = 1'b1;
            end
            if (!pins.line_discard_gate && p_r.line_discard_gate)
                quiet_until = cyc + GUARD;
            if (edge_w) begin
                if (cyc < quiet_until) viol++;
                last_edge = cyc;
            end
            // horizontal period, measured within a row only
            if (pins.horizontal_phase_one && !p_r.horizontal_phase_one) begin
                if (!gap_r && hcnt_r < hmin) hmin = hcnt_r;
                if (!gap_r && hcnt_r > hmax) hmax = hcnt_r;
                gap_r = 1'b0;
                hcnt_r = 8'h00;
            end
            p_r = pins;
        end
    end
endmodule : ccdrs_sensor_model
`default_nettype wire

/* File: bench/ccd_readout_sequencer_bench.sv */
// bench: random-drained frames in every scan mode
// assumes: shortened timing parameters, 125 MHz clk
`timescale 1ns/1ps
`default_nettype none
module ccd_readout_sequencer_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    ccdrs_pkg::ccdrs_mode_t scan_mode = ccdrs_pkg::CCDRS_PROG;
    ccdrs_pkg::ccdrs_mode_t cur_mode = ccdrs_pkg::CCDRS_PROG;
    logic full_range = 1'b0;
    logic start = 1'b0;
    logic [23:0] integration_cycles = 24'h000010;
    logic row_ready = 1'b0;
    logic busy, end_of_frame, frame_incomplete, row_valid;
    ccdrs_pkg::ccdrs_row_t row_data;
    ccdrs_pkg::ccdrs_pins_t pins;
    logic [15:0] vshifts, xfers, shut_miss, viol;
    logic [7:0] hmin, hmax;
    logic [7:0] hnom = 8'h00;
    logic [31:0] lfsr = 32'hEB8A;
    logic stall = 1'b0;
    logic cur_odd = 1'b0;
    int err_count = 0;
    int n_tests = 0;
    int idx = 0;
    int cur_rows = 0;
    int nfr = 0;

    ///////////////////////////////////////////////////////////
    // clock, design and sensor model
    always #4 clk = ~clk;

    ccdrs_sequencer #(.PIX_PER_ROW(2), .FD_CYC(1), .VT_CYC(2),
        .V3_CYC(2), .TS_CYC(2)) uut (
        .clk(clk), .sys_rst(sys_rst), .scan_mode(scan_mode),
        .full_range(full_range), .start(start),
        .integration_cycles(integration_cycles), .busy(busy),
        .end_of_frame(end_of_frame), .frame_incomplete(frame_incomplete),
        .row_valid(row_valid), .row_ready(row_ready),
        .row_data(row_data), .pins(pins));

    ccdrs_sensor_model u_sensor (
        .clk(clk), .sys_rst(sys_rst), .pins(pins), .vshifts(vshifts),
        .xfers(xfers), .shut_miss(shut_miss), .viol(viol),
        .hmin(hmin), .hmax(hmax));

    // lfsr step for random values
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // expected row number of the i-th marker
    function automatic logic [31:0] exp_row(input int i);
        if (cur_mode == ccdrs_pkg::CCDRS_PROG)
            return 32'(i);
        return 32'(2 * i + int'(cur_odd));
    endfunction : exp_row

    // compare and count
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // closing report
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // random drain of row markers, held off in the stall window
    always @(posedge clk) begin
        lfsr <= lfsr_next(lfsr);
        row_ready <= !stall && lfsr[3];
        if (row_valid && row_ready) begin
            check("row", 32'(row_data.row), exp_row(idx));
            check("last", 32'(row_data.last), 32'(idx == cur_rows - 1));
            check("parity", 32'(row_data.field_odd), 32'(cur_odd));
            idx <= idx + 1;
        end
    end

    // one frame or field from start to end of frame
    task automatic run_frame(input ccdrs_pkg::ccdrs_mode_t m,
        input logic fr, input int rows);
        int k;
        @(posedge clk);
        cur_mode = m;
        cur_rows = rows;
        nfr++;
        idx <= 0;
        scan_mode <= m;
        full_range <= fr;
        integration_cycles <= 24'(lfsr[5:0]) + 24'h000004;
        start <= 1'b1;
        stall <= (m == ccdrs_pkg::CCDRS_SUMMED) && !cur_odd;
        @(posedge clk);
        start <= 1'b0;
        #1;
        check("busy", 32'(busy), 32'h1);
        repeat (600) @(posedge clk);
        #1;
        check("incomplete", 32'(frame_incomplete),
            32'(m != ccdrs_pkg::CCDRS_PROG && !cur_odd));
        if (stall)
            check("stalled", 32'(vshifts <= 16'd10), 32'h1);
        // a start while busy, with CCDRS_NONSUM, is ignored
        @(posedge clk);
        stall <= 1'b0;
        scan_mode <= ccdrs_pkg::CCDRS_NONSUM;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (k = 0; k < 80000 && end_of_frame !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == 80000) begin
            check("timeout", 32'h0, 32'h1);
            print_verdict();
        end
        check("vshifts", 32'(vshifts), 32'(rows));
        check("xfers", 32'(xfers), 32'(nfr));
        check("shutter", 32'(shut_miss), 32'h0);
        check("guard", 32'(viol), 32'h0);
        check("hfast", 32'(32'(hmin) * 8 >= 25), 32'h1);
        check("hslow", 32'(32'(hmax) * 8 <= 200), 32'h1);
        if (m == ccdrs_pkg::CCDRS_PROG)
            hnom = hmax;
        if (m == ccdrs_pkg::CCDRS_SUMMED && fr)
            check("rate", 32'(hmin > hnom), 32'h1);
        @(posedge clk);
        #1;
        check("eof", 32'(end_of_frame), 32'h0);
        check("idle", 32'(busy), 32'h0);
        for (k = 0; k < 40 && idx != rows; k++)
            @(posedge clk);
        check("rows", 32'(idx), 32'(rows));
        if (m != ccdrs_pkg::CCDRS_PROG)
            cur_odd = !cur_odd;
    endtask : run_frame

    ///////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        check("pins", 32'(pins), 32'h0);
        sys_rst <= 1'b0;
        run_frame(ccdrs_pkg::CCDRS_PROG, 1'b0, 2048);
        run_frame(ccdrs_pkg::CCDRS_SUMMED, 1'b1, 1037);
        run_frame(ccdrs_pkg::CCDRS_SUMMED, 1'b0, 1037);
        run_frame(ccdrs_pkg::CCDRS_NONSUM, lfsr[0], 1037);
        print_verdict();
    end
endmodule : ccd_readout_sequencer_bench
`default_nettype wire
